//--- inc/twg_regs.svh
// register map, field positions, reset values and timing counts of the waveform generator
`ifndef TWG_REGS_SVH
`define TWG_REGS_SVH
`define TWG_CONFIG_ADDR    16'h2014
`define TWG_LEVEL1_ADDR    16'h2018
`define TWG_LEVEL2_ADDR    16'h201c
`define TWG_HOLD1_ADDR     16'h2020
`define TWG_RAMP1_ADDR     16'h2024
`define TWG_HOLD2_ADDR     16'h2028
`define TWG_RAMP2_ADDR     16'h202c
`define TWG_FECTRL_ADDR    16'h2100
`define TWG_FASTDAC_ADDR   16'h2104
`define TWG_LPCTRL_ADDR    16'h2108
`define TWG_LPOFS_ADDR     16'h210c
`define TWG_HPOFS_ADDR     16'h2110
`define TWG_LPATT_ADDR     16'h2114
`define TWG_HPATT_ADDR     16'h2118
`define TWG_OUTSTAT_ADDR   16'h211c
`define TWG_CFG_RESTART    0
`define TWG_CFG_TYPE_LO    1
`define TWG_CFG_OFSCAL     4
`define TWG_CFG_GAINCAL    5
`define TWG_FE_ENABLE      0
`define TWG_FE_HIPOWER     1
`define TWG_LP_ATTEN       0
`define TWG_CFG_RESET      32'h0000_0030
`define TWG_CLK_HZ         50000000
`define TWG_UPDATE_HZ      320000
`define TWG_TICK_CYC       (`TWG_CLK_HZ / `TWG_UPDATE_HZ)
`endif

//--- inc/twg_pkg.sv
// types shared by the waveform generator
package twg_pkg;
  // gray-coded trapezoid phases
  typedef enum logic [1:0] {
    TWG_HOLD1 = 2'b00,
    TWG_RAMP1 = 2'b01,
    TWG_HOLD2 = 2'b11,
    TWG_RAMP2 = 2'b10
  } twg_phase_t;
  typedef enum logic [1:0] {
    TWG_DIRECT = 2'b00,
    TWG_RSVD   = 2'b01,
    TWG_SINE   = 2'b10,
    TWG_TRAP   = 2'b11
  } twg_wave_t;
  typedef logic [11:0] twg_sample_t;
endpackage

//--- hw/twg_top.sv
// waveform generator control, trapezoid engine, apb registers and sample fifo
//
// How it works
// (RQ1) offset correction picks plain or attenuated offsets by attenuation bit 0
// (RQ2) type 00 sends software samples from the fast dac register to dac
// (RQ3) type 10 picks sine source and sets generator enable
// (RQ4) type 11 picks trapezoid source and sets generator enable
// (RQ5) restart bit set puts trapezoid at hold one, first level, immediately
// (RQ6) restart bit is write-only and clears itself after the restart
// (RQ7) first level is 12 bits read/write, upper bits read zero
// (RQ8) second level is 12 bits read/write, upper bits read zero
// (RQ9) first hold is a 20-bit count of update periods
// (RQ10) first ramp is a 20-bit count at fixed 320 kHz update
// (RQ11) second hold is a 20-bit count at fixed 320 kHz update
// (RQ12) second ramp is a 20-bit count at fixed 320 kHz update
// (RQ13) period runs hold one to ramp two and repeats; zero ramp gives square
// (RQ14) disabled generator holds last output until new type or restart
// (RQ15) hold first level, ramp up, hold second level, ramp back
`timescale 1ns/1ps
`default_nettype none
`include "twg_regs.svh"

// ----------------------------------------------------------------
// sample fifo
// ----------------------------------------------------------------
module twg_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  assign in_ready  = (fill != DEPTH[AW:0]);
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage has no reset, only pointers matter
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers wrap at depth, depth need not be a power of two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ----------------------------------------------------------------
// generator top
// ----------------------------------------------------------------
module twg_top (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire twg_pkg::twg_sample_t sine_sample,
  output logic                    dac_valid,
  input  wire logic               dac_ready,
  output twg_pkg::twg_sample_t    dac_sample
);
  import twg_pkg::*;

  logic [31:0] wave_gen_config;
  logic [11:0] trap_level_one;
  logic [11:0] trap_level_two;
  logic [19:0] trap_first_hold_time;
  logic [19:0] trap_first_ramp_time;
  logic [19:0] trap_second_hold_time;
  logic [19:0] trap_second_ramp_time;
  logic [1:0]  front_end_control;
  logic [11:0] fast_dac_sample;
  logic        low_power_converter_control;
  logic [11:0] low_power_offset_value;
  logic [11:0] high_power_offset_value;
  logic [11:0] low_power_attenuated_offset;
  logic [11:0] high_power_attenuated_offset;
  logic        trap_restart;
  twg_wave_t   wave_type_select;
  twg_phase_t  phase;
  twg_phase_t  next_phase;
  logic [19:0] cnt;
  logic [19:0] next_cnt;
  logic [7:0]  div_cnt;
  logic        tick_pend;
  logic        kick;
  logic        acc;
  logic        wr_go;
  logic        rd_go;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [11:0] fifo_out_data;
  logic        pop;
  logic        gen_push;
  logic        dac_wr;
  logic        push;
  logic [11:0] trap_value;
  logic [11:0] raw_sample;
  logic [11:0] offset_sel;
  logic [11:0] push_data;
  logic [19:0] dur;
  logic        wave_gen_enable;

  // address decode shared by read and write paths
  function automatic logic twg_hit(input logic [31:0] a);
    case (a[15:0])
      `TWG_CONFIG_ADDR, `TWG_LEVEL1_ADDR, `TWG_LEVEL2_ADDR, `TWG_HOLD1_ADDR,
      `TWG_RAMP1_ADDR, `TWG_HOLD2_ADDR, `TWG_RAMP2_ADDR, `TWG_FECTRL_ADDR,
      `TWG_FASTDAC_ADDR, `TWG_LPCTRL_ADDR, `TWG_LPOFS_ADDR, `TWG_HPOFS_ADDR,
      `TWG_LPATT_ADDR, `TWG_HPATT_ADDR, `TWG_OUTSTAT_ADDR: twg_hit = (a[31:16] == 16'h0000);
      default: twg_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign wave_type_select = twg_wave_t'(wave_gen_config[`TWG_CFG_TYPE_LO +: 2]);
  assign wave_gen_enable  = front_end_control[`TWG_FE_ENABLE];
  assign acc    = psel & penable & ~pready;
  // a direct sample write waits while the fifo is full
  assign dac_wr = acc & pwrite & (paddr == {16'h0000, `TWG_FASTDAC_ADDR});
  assign wr_go  = acc & pwrite & (~dac_wr | fifo_in_ready);
  assign rd_go  = acc & ~pwrite;

  // handshake: pready one cycle into the access phase, unless stalled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= wr_go | rd_go;
      pslverr <= (wr_go | rd_go) & ~twg_hit(paddr);
    end
  end

  // read data; reserved bits and the restart bit read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_go) begin
      case (paddr[15:0])
        `TWG_CONFIG_ADDR:  prdata <= {26'h0, wave_gen_config[5:1], 1'b0};
        // (RQ7) twelve bit level
        `TWG_LEVEL1_ADDR:  prdata <= {20'h0, trap_level_one};
        // (RQ8) twelve bit level
        `TWG_LEVEL2_ADDR:  prdata <= {20'h0, trap_level_two};
        `TWG_HOLD1_ADDR:   prdata <= {12'h0, trap_first_hold_time};
        `TWG_RAMP1_ADDR:   prdata <= {12'h0, trap_first_ramp_time};
        `TWG_HOLD2_ADDR:   prdata <= {12'h0, trap_second_hold_time};
        `TWG_RAMP2_ADDR:   prdata <= {12'h0, trap_second_ramp_time};
        `TWG_FECTRL_ADDR:  prdata <= {30'h0, front_end_control};
        `TWG_FASTDAC_ADDR: prdata <= {20'h0, fast_dac_sample};
        `TWG_LPCTRL_ADDR:  prdata <= {31'h0, low_power_converter_control};
        `TWG_LPOFS_ADDR:   prdata <= {20'h0, low_power_offset_value};
        `TWG_HPOFS_ADDR:   prdata <= {20'h0, high_power_offset_value};
        `TWG_LPATT_ADDR:   prdata <= {20'h0, low_power_attenuated_offset};
        `TWG_HPATT_ADDR:   prdata <= {20'h0, high_power_attenuated_offset};
        `TWG_OUTSTAT_ADDR: prdata <= {18'h0, phase, dac_sample};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

  // parameter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_level_one               <= 12'h000;
      trap_level_two               <= 12'h000;
      trap_first_hold_time         <= 20'h00000;
      trap_first_ramp_time         <= 20'h00000;
      trap_second_hold_time        <= 20'h00000;
      trap_second_ramp_time        <= 20'h00000;
      fast_dac_sample              <= 12'h000;
      low_power_converter_control  <= 1'b0;
      low_power_offset_value       <= 12'h000;
      high_power_offset_value      <= 12'h000;
      low_power_attenuated_offset  <= 12'h000;
      high_power_attenuated_offset <= 12'h000;
    end else if (wr_go) begin
      case (paddr[15:0])
        `TWG_LEVEL1_ADDR:  trap_level_one <= pwdata[11:0];
        `TWG_LEVEL2_ADDR:  trap_level_two <= pwdata[11:0];
        // (RQ9) hold one width
        `TWG_HOLD1_ADDR:   trap_first_hold_time <= pwdata[19:0];
        // (RQ10) ramp one width
        `TWG_RAMP1_ADDR:   trap_first_ramp_time <= pwdata[19:0];
        // (RQ11) hold two width
        `TWG_HOLD2_ADDR:   trap_second_hold_time <= pwdata[19:0];
        // (RQ12) ramp two width
        `TWG_RAMP2_ADDR:   trap_second_ramp_time <= pwdata[19:0];
        `TWG_FASTDAC_ADDR: fast_dac_sample <= pwdata[11:0];
        `TWG_LPCTRL_ADDR:  low_power_converter_control <= pwdata[`TWG_LP_ATTEN];
        `TWG_LPOFS_ADDR:   low_power_offset_value <= pwdata[11:0];
        `TWG_HPOFS_ADDR:   high_power_offset_value <= pwdata[11:0];
        `TWG_LPATT_ADDR:   low_power_attenuated_offset <= pwdata[11:0];
        `TWG_HPATT_ADDR:   high_power_attenuated_offset <= pwdata[11:0];
        default: ;
      endcase
    end
  end

  // configuration and front end control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_gen_config   <= `TWG_CFG_RESET;
      front_end_control <= 2'b00;
    end else if (wr_go && paddr[15:0] == `TWG_CONFIG_ADDR) begin
      wave_gen_config <= {26'h0, pwdata[5:4], 1'b0, pwdata[2:1], 1'b0};
      // (RQ3) (RQ4) generator types turn the generator on
      if (pwdata[`TWG_CFG_TYPE_LO + 1]) begin
        front_end_control[`TWG_FE_ENABLE] <= 1'b1;
      end
    end else if (wr_go && paddr[15:0] == `TWG_FECTRL_ADDR) begin
      front_end_control <= pwdata[1:0];
    end
  end

  // (RQ6) restart is a one-cycle pulse, never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_restart <= 1'b0;
    end else begin
      trap_restart <= wr_go & (paddr[15:0] == `TWG_CONFIG_ADDR) & pwdata[`TWG_CFG_RESTART];
    end
  end

  // ----------------------------------------------------------------
  // update clock and trapezoid engine
  // ----------------------------------------------------------------
  // update tick; a tick not yet taken waits while the fifo is full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt   <= 8'h00;
      tick_pend <= 1'b0;
    end else if (trap_restart) begin
      // (RQ5) restart also restarts the update period, so hold one lasts a full tick
      div_cnt   <= 8'h00;
      tick_pend <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == 8'(`TWG_TICK_CYC - 1)) ? 8'h00 : div_cnt + 8'h01;
      if (div_cnt == 8'(`TWG_TICK_CYC - 1)) begin
        tick_pend <= 1'b1;
      end else if (gen_push || kick) begin
        // a tick left over from a stop must not cut the first phase short
        tick_pend <= 1'b0;
      end
    end
  end

  // width of the present phase
  always_comb begin
    case (phase)
      TWG_HOLD1: dur = trap_first_hold_time;
      TWG_RAMP1: dur = trap_first_ramp_time;
      TWG_HOLD2: dur = trap_second_hold_time;
      TWG_RAMP2: dur = trap_second_ramp_time;
      default:   dur = trap_first_hold_time;
    endcase
  end

  // (RQ13) (RQ15) phase order; a zero width lasts only one update
  always_comb begin
    next_phase = phase;
    next_cnt   = cnt + 20'h00001;
    if (next_cnt >= dur) begin
      next_cnt = 20'h00000;
      case (phase)
        TWG_HOLD1: next_phase = TWG_RAMP1;
        TWG_RAMP1: next_phase = TWG_HOLD2;
        TWG_HOLD2: next_phase = TWG_RAMP2;
        TWG_RAMP2: next_phase = TWG_HOLD1;
        default:   next_phase = TWG_HOLD1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= TWG_HOLD1;
      cnt   <= 20'h00000;
    end else if (trap_restart) begin
      // (RQ5) restart at the head of hold one
      phase <= TWG_HOLD1;
      cnt   <= 20'h00000;
    end else if (gen_push && wave_type_select == TWG_TRAP) begin
      phase <= next_phase;
      cnt   <= next_cnt;
    end
  end

  // (RQ15) linear ramp value; quotient never exceeds the level gap
  always_comb begin
    logic signed [12:0] gap;
    logic signed [33:0] num;
    logic signed [33:0] quo;
    logic        [11:0] base;
    gap  = 13'sd0;
    num  = 34'sd0;
    quo  = 34'sd0;
    base = trap_level_one;
    if (phase == TWG_RAMP2) begin
      base = trap_level_two;
      gap  = $signed({1'b0, trap_level_one}) - $signed({1'b0, trap_level_two});
    end else begin
      gap  = $signed({1'b0, trap_level_two}) - $signed({1'b0, trap_level_one});
    end
    num = $signed({{21{gap[12]}}, gap}) * $signed({14'h0000, cnt});
    if (dur != 20'h00000) begin
      quo = num / $signed({14'h0000, dur});
    end
    case (phase)
      TWG_HOLD1: trap_value = trap_level_one;
      TWG_HOLD2: trap_value = trap_level_two;
      default:   trap_value = base + quo[11:0];
    endcase
  end

  // ----------------------------------------------------------------
  // source select, offset correction and fifo feed
  // ----------------------------------------------------------------
  // (RQ2) source per waveform type
  always_comb begin
    case (wave_type_select)
      TWG_SINE: raw_sample = sine_sample;
      TWG_TRAP: raw_sample = trap_value;
      default:  raw_sample = (dac_wr) ? pwdata[11:0] : fast_dac_sample;
    endcase
  end

  // (RQ1) correction source by power mode and attenuation
  always_comb begin
    case ({low_power_converter_control, front_end_control[`TWG_FE_HIPOWER]})
      2'b00:   offset_sel = low_power_offset_value;
      2'b01:   offset_sel = high_power_offset_value;
      2'b10:   offset_sel = low_power_attenuated_offset;
      default: offset_sel = high_power_attenuated_offset;
    endcase
  end
  // sum wraps at twelve bits, no saturation
  assign push_data = wave_gen_config[`TWG_CFG_OFSCAL] ? 12'(raw_sample + offset_sel) : raw_sample;

  // (RQ14) kick sends one fresh sample after a sine or trapezoid type write or restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kick <= 1'b0;
    end else if (trap_restart || (wr_go && paddr[15:0] == `TWG_CONFIG_ADDR
                                  && pwdata[`TWG_CFG_TYPE_LO + 1])) begin
      kick <= 1'b1;
    end else if (push && !dac_wr) begin
      kick <= 1'b0;
    end
  end

  // (RQ14) disabled generator stops feeding, the dac keeps its last value
  assign gen_push = fifo_in_ready & tick_pend & wave_gen_enable & ~kick & ~trap_restart
                    & wave_type_select[1];
  assign push     = (dac_wr & wr_go & ~wave_type_select[1]) | gen_push
                    | (kick & fifo_in_ready & ~trap_restart & wave_type_select[1]);

  twg_fifo #(
    .WIDTH (12),
    .DEPTH (4)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // output stage keeps the last sample when the fifo runs dry
  assign pop = fifo_out_valid & (~dac_valid | dac_ready);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_valid  <= 1'b0;
      dac_sample <= 12'h000;
    end else begin
      if (pop) begin
        dac_sample <= fifo_out_data;
      end
      dac_valid <= pop | (dac_valid & ~dac_ready);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_restart_clears;
    @(posedge pclk) disable iff (!presetn) trap_restart |=> !trap_restart;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("restart stuck"); // RQ6

  property p_restart_head;
    @(posedge pclk) disable iff (!presetn)
      trap_restart |=> (phase == TWG_HOLD1) && (cnt == 20'h00000) && (trap_value == trap_level_one);
  endproperty
  a_restart_head: assert property (p_restart_head) else $error("restart not at hold one"); // RQ5

  property p_sine_enable;
    @(posedge pclk) disable iff (!presetn)
      wr_go && paddr[15:0] == `TWG_CONFIG_ADDR && pwdata[2:1] == 2'b10
      |=> wave_gen_enable && wave_type_select == TWG_SINE;
  endproperty
  a_sine_enable: assert property (p_sine_enable) else $error("sine not enabled"); // RQ3

  property p_trap_enable;
    @(posedge pclk) disable iff (!presetn)
      wr_go && paddr[15:0] == `TWG_CONFIG_ADDR && pwdata[2:1] == 2'b11
      |=> wave_gen_enable && wave_type_select == TWG_TRAP;
  endproperty
  a_trap_enable: assert property (p_trap_enable) else $error("trapezoid not enabled"); // RQ4

  property p_level_read;
    @(posedge pclk) disable iff (!presetn)
      rd_go && paddr[15:0] == `TWG_LEVEL1_ADDR |=> prdata == {20'h0, trap_level_one};
  endproperty
  a_level_read: assert property (p_level_read) else $error("level read wrong"); // RQ7

  property p_offset_plain;
    @(posedge pclk) disable iff (!presetn)
      push && wave_gen_config[4] && !low_power_converter_control && !front_end_control[1]
      |-> push_data == 12'(raw_sample + low_power_offset_value);
  endproperty
  a_offset_plain: assert property (p_offset_plain) else $error("offset source wrong"); // RQ1

  property p_direct;
    @(posedge pclk) disable iff (!presetn)
      wr_go && dac_wr && wave_type_select == TWG_DIRECT && !wave_gen_config[4]
      |-> push && push_data == pwdata[11:0];
  endproperty
  a_direct: assert property (p_direct) else $error("direct sample lost"); // RQ2

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      gen_push && wave_type_select == TWG_TRAP && phase == TWG_RAMP2 && cnt + 20'h1 >= dur
      && !trap_restart |=> phase == TWG_HOLD1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("period did not repeat"); // RQ13

  property p_hold_off;
    @(posedge pclk) disable iff (!presetn)
      !wave_gen_enable && wave_type_select[1] && !kick |-> !push;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("disabled generator pushed"); // RQ14

  property p_hold_two;
    @(posedge pclk) disable iff (!presetn) phase == TWG_HOLD2 |-> trap_value == trap_level_two;
  endproperty
  a_hold_two: assert property (p_hold_two) else $error("hold two level wrong"); // RQ15
endmodule
`default_nettype wire

//--- verif/twg_dac_model.sv
// dac sink model that can stall and records every accepted sample
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// dac sink
// ----------------------------------------------------------------
module twg_dac_model (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 stall,
  input  wire logic                 dac_valid,
  input  wire twg_pkg::twg_sample_t dac_sample,
  output logic                      dac_ready
);
  import twg_pkg::*;
  twg_sample_t got[$];
  // ready drops while stalled, so the fifo backs up
  assign dac_ready = presetn && !stall;
  // record each accepted beat in arrival order
  always @(posedge pclk) begin
    if (dac_valid === 1'b1 && dac_ready) begin
      got.push_back(dac_sample);
    end
  end
endmodule
`default_nettype wire

//--- verif/trapezoid_waveform_generator_tb.sv
// self-checking bench of the waveform generator over apb
`timescale 1ns/1ps
`default_nettype none
`include "twg_regs.svh"

module trapezoid_waveform_generator_tb;
  import twg_pkg::*;
  localparam int TICK = `TWG_TICK_CYC;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        dac_valid, dac_ready, stall;
  logic [31:0] paddr, pwdata, prdata, r;
  twg_sample_t sine_s, dac_sample;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          n;
  logic        e, hit1, hit2, hitm, bad;
  logic [15:0] ra[6] = '{16'h2018, 16'h201c, 16'h2020, 16'h2024, 16'h2028, 16'h202c};
  logic [31:0] rm[6] = '{32'hfff, 32'hfff, 32'hfffff, 32'hfffff, 32'hfffff, 32'hfffff};
  logic [31:0] tv[6] = '{32'h100, 32'h200, 32'h1, 32'h2, 32'h1, 32'h0};
  twg_sample_t ofs[4] = '{12'h005, 12'h00a, 12'h050, 12'h0a0};

  twg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sine_sample(sine_s), .dac_valid(dac_valid),
    .dac_ready(dac_ready), .dac_sample(dac_sample));
  twg_dac_model u_dac (.pclk(pclk), .presetn(presetn), .stall(stall),
    .dac_valid(dac_valid), .dac_sample(dac_sample), .dac_ready(dac_ready));

  // 50 MHz clock
  always #10 pclk = ~pclk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; the wait is bounded since a full fifo stalls writes
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {16'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 300);
    if (pready !== 1'b1) begin
      fail_count++;
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, r, exp);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; sine_s = 12'h3a5; stall = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(`TWG_CONFIG_ADDR, 32'h30, "config reset");
    // reserved bits read zero, full field width kept
    for (int i = 0; i < 6; i++) begin
      rd_chk(ra[i], 32'h0, "param reset");
      apb(1'b1, ra[i], 32'hffff_ffff);
      rd_chk(ra[i], rm[i], "param width");
    end
    // unmapped place answers with an error and zero
    apb(1'b1, 16'h2050, 32'h1234);
    rd_chk(16'h2050, 32'h0, "unmapped data");
    check("unmapped err", e, 1'b1);
    // direct samples through a stalled dac, sixth write waits for room
    apb(1'b1, `TWG_CONFIG_ADDR, 32'h0);
    stall <= 1'b1;
    fork
      begin
        repeat (60) @(posedge pclk);
        stall <= 1'b0;
      end
    join_none
    for (int i = 1; i <= 6; i++) apb(1'b1, `TWG_FASTDAC_ADDR, i);
    repeat (20) @(posedge pclk);
    check("direct count", u_dac.got.size(), 6);
    for (int i = 0; i < 6; i++) check("direct order", u_dac.got[i], i + 1);
    // offset source by power mode and attenuation
    apb(1'b1, `TWG_CONFIG_ADDR, 32'h10);
    apb(1'b1, `TWG_LPOFS_ADDR, ofs[0]);
    apb(1'b1, `TWG_LPATT_ADDR, ofs[1]);
    apb(1'b1, `TWG_HPOFS_ADDR, ofs[2]);
    apb(1'b1, `TWG_HPATT_ADDR, ofs[3]);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `TWG_FECTRL_ADDR, {30'h0, k[1], 1'b0});
      apb(1'b1, `TWG_LPCTRL_ADDR, {31'h0, k[0]});
      apb(1'b1, `TWG_FASTDAC_ADDR, 32'h100);
      repeat (10) @(posedge pclk);
      check("offset", u_dac.got[$], 12'h100 + ofs[k]);
    end
    // trapezoid: levels 100/200, hold 1, ramp 2, hold 1, ramp 0
    apb(1'b1, `TWG_CONFIG_ADDR, 32'h0);
    apb(1'b1, `TWG_FECTRL_ADDR, 32'h0);
    for (int i = 0; i < 6; i++) apb(1'b1, ra[i], tv[i]);
    u_dac.got.delete();
    apb(1'b1, `TWG_CONFIG_ADDR, 32'h6);
    rd_chk(`TWG_FECTRL_ADDR, 32'h1, "trap enable");
    repeat (12 * TICK) @(posedge pclk);
    {hit1, hit2, hitm, bad} = 4'b0;
    foreach (u_dac.got[i]) begin
      hit1 |= (u_dac.got[i] === 12'h100);
      hit2 |= (u_dac.got[i] === 12'h200);
      hitm |= (u_dac.got[i] === 12'h180);
      bad |= (u_dac.got[i] < 12'h100) || (u_dac.got[i] > 12'h200);
    end
    check("trap shape", {hit1, hit2, hitm, bad}, 4'b1110);
    check("trap rate", u_dac.got.size() >= 10, 1'b1);
    // sine source, then disable holds the output
    apb(1'b1, `TWG_FECTRL_ADDR, 32'h0);
    apb(1'b1, `TWG_CONFIG_ADDR, 32'h4);
    rd_chk(`TWG_FECTRL_ADDR, 32'h1, "sine enable");
    repeat (2 * TICK) @(posedge pclk);
    check("sine sample", u_dac.got[$], 12'h3a5);
    apb(1'b1, `TWG_FECTRL_ADDR, 32'h0);
    // let a sample already in flight land before counting
    repeat (4) @(posedge pclk);
    n = u_dac.got.size();
    repeat (3 * TICK) @(posedge pclk);
    check("held count", u_dac.got.size(), n);
    check("held value", dac_sample, 12'h3a5);
    // restart lands on hold one at level one, bit reads back zero
    apb(1'b1, `TWG_CONFIG_ADDR, 32'h7);
    repeat (4) @(posedge pclk);
    rd_chk(`TWG_OUTSTAT_ADDR, 32'h100, "restart state");
    rd_chk(`TWG_CONFIG_ADDR, 32'h6, "restart clear");
    finish_test();
  end
endmodule
`default_nettype wire
